// [rtl/drcd_top.sv]
// Dual ratio clock divider: picks one input clock, divides by 2 and 4.
// Assumes input clocks are sampled synchronously to mclk and are slower
// than half of mclk, so each input rising edge is seen as one edge.
`timescale 1ns/1ps
module drcd_top #(
	parameter int N_DIV2 = drcd_pkg::DIV2_OUTS,
	parameter int N_DIV4 = drcd_pkg::DIV4_OUTS
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic source_sel,
	input wire logic diff_pecl_clk_in_p,
	input wire logic diff_pecl_clk_in_n,
	input wire logic diff_pecl_open,
	input wire logic ttl_clock_in,
	output logic [N_DIV2-1:0] divided_clk_out_div2,
	output logic [N_DIV2-1:0] divided_clk_out_div2_n,
	output logic [N_DIV4-1:0] divided_clk_out_div4,
	output logic [N_DIV4-1:0] divided_clk_out_div4_n
);
	typedef enum logic [1:0] {
		DRCD_LOW = 2'h1,
		DRCD_HIGH = 2'h2
	} drcd_lvl_t;

	logic pecl_level;
	logic sel_clk;
	logic [1:0] phase;
	logic [1:0] next_phase;
	drcd_lvl_t src_state;
	drcd_lvl_t next_src_state;
	logic rise;

	// Refuse output counts that the generate loops cannot serve
	generate
		if (N_DIV2 < 1 || N_DIV4 < 1) begin : g_bad_count
			$error("drcd_top needs at least one output per ratio");
		end
	endgenerate

	// Open pair is held low; otherwise high only with true side high and complement low
	always_comb begin
		pecl_level = diff_pecl_clk_in_p & ~diff_pecl_clk_in_n;
		if (diff_pecl_open) begin
			pecl_level = 1'h0;
		end
	end

	// Source mux, ahead of the edge detector so both ratios share it
	always_comb begin
		if (source_sel == drcd_pkg::SEL_PECL) begin
			sel_clk = pecl_level;
		end else begin
			sel_clk = ttl_clock_in;
		end
	end

	// Edge tracking of the selected clock level as a two-state machine;
	// a rise is taken only from the low state, so a level that sits high
	// for many mclk cycles still counts as a single edge
	always_comb begin
		next_src_state = src_state;
		rise = 1'h0;
		unique case (src_state)
			DRCD_LOW: begin
				if (sel_clk) begin
					next_src_state = DRCD_HIGH;
					rise = 1'h1;
				end
			end
			DRCD_HIGH: begin
				if (!sel_clk) begin
					next_src_state = DRCD_LOW;
				end
			end
			default: begin
				next_src_state = DRCD_LOW; // Illegal code falls back low
			end
		endcase
	end

	// One shared counter keeps the two ratios locked in phase. It counts
	// down (00, 11, 10, 01), so bit 1 flips only when bit 0 rises: a
	// slow rising edge can then never land on a fast falling edge.
	always_comb begin
		next_phase = phase;
		if (rise) begin
			next_phase = phase - 2'h1;
		end
	end

	// Previous level starts low so a high input at release counts once
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			src_state <= DRCD_LOW;
			phase <= drcd_pkg::PHASE_RESET;
		end else begin
			src_state <= next_src_state;
			phase <= next_phase;
		end
	end

	// Outputs toggle in the same cycle as the counter, all through flops
	genvar gi;
	generate
		for (gi = 0; gi < N_DIV2; gi++) begin : g_div2
			drcd_out_pair u_pair (
				.mclk(mclk),
				.nrst(nrst),
				.level(next_phase[drcd_pkg::DIV2_BIT]),
				.q(divided_clk_out_div2[gi]),
				.q_n(divided_clk_out_div2_n[gi])
			);
		end
		for (gi = 0; gi < N_DIV4; gi++) begin : g_div4
			drcd_out_pair u_pair (
				.mclk(mclk),
				.nrst(nrst),
				.level(next_phase[drcd_pkg::DIV4_BIT]),
				.q(divided_clk_out_div4[gi]),
				.q_n(divided_clk_out_div4_n[gi])
			);
		end
	endgenerate

	// Rising slow edge always lands with a rising fast edge
	AST_ALIGN: assert property (
		@(posedge mclk) disable iff (!nrst)
		$rose(divided_clk_out_div4[0]) |-> $rose(divided_clk_out_div2[0]))
		else $error("slow rising edge without fast rising edge");

	// Complements are the exact inverse while running
	AST_COMPL: assert property (
		@(posedge mclk) disable iff (!nrst)
		divided_clk_out_div2_n[0] == ~divided_clk_out_div2[0])
		else $error("div2 complement mismatch");
	AST_COMPL4: assert property (
		@(posedge mclk) disable iff (!nrst)
		divided_clk_out_div4_n[0] == ~divided_clk_out_div4[0])
		else $error("div4 complement mismatch");

	// Each taken edge moves div2; div4 moves with every div2 rise only
	AST_HALF2: assert property (
		@(posedge mclk) disable iff (!nrst)
		rise |=> divided_clk_out_div2[0] != $past(divided_clk_out_div2[0]))
		else $error("div2 did not toggle on input edge");
	AST_QUIET2: assert property (
		@(posedge mclk) disable iff (!nrst)
		!rise |=> $stable(divided_clk_out_div2[0]))
		else $error("div2 moved without input edge");
	AST_QUIET: assert property (
		@(posedge mclk) disable iff (!nrst)
		!rise |=> $stable(divided_clk_out_div4[0]))
		else $error("div4 moved without input edge");
	AST_DIV4: assert property (
		@(posedge mclk) disable iff (!nrst)
		(rise && !divided_clk_out_div2[0]) |=>
			divided_clk_out_div4[0] != $past(divided_clk_out_div4[0]))
		else $error("div4 did not toggle with a div2 rise");
	AST_DIV4_HOLD: assert property (
		@(posedge mclk) disable iff (!nrst)
		(rise && divided_clk_out_div2[0]) |=>
			$stable(divided_clk_out_div4[0]))
		else $error("div4 toggled with a div2 fall");

	// Edge detector never takes two rises back to back
	AST_ONE_RISE: assert property (
		@(posedge mclk) disable iff (!nrst)
		rise |=> !rise)
		else $error("two input rises in consecutive cycles");

	// Open pair reads low; the select pin routes the chosen source
	AST_OPEN: assert property (
		@(posedge mclk) disable iff (!nrst)
		(diff_pecl_open && source_sel == drcd_pkg::SEL_PECL) |-> !sel_clk)
		else $error("open pair not held low");
	AST_SEL_TTL: assert property (
		@(posedge mclk) disable iff (!nrst)
		source_sel == drcd_pkg::SEL_TTL |-> sel_clk == ttl_clock_in)
		else $error("TTL source not routed");
	AST_SEL_PECL: assert property (
		@(posedge mclk) disable iff (!nrst)
		(source_sel == drcd_pkg::SEL_PECL && !diff_pecl_open) |->
			sel_clk == (diff_pecl_clk_in_p && !diff_pecl_clk_in_n))
		else $error("differential source not routed");

	// Reset holds the output pins; release starts both ratios low
	AST_START: assert property (
		@(posedge mclk)
		$rose(nrst) |-> !divided_clk_out_div2[0] && !divided_clk_out_div4[0])
		else $error("dividers not low after reset");
	AST_RST: assert property (
		@(posedge mclk)
		!nrst |-> !divided_clk_out_div4[0] && divided_clk_out_div4_n[0])
		else $error("div4 reset state wrong");
	AST_RST_DIV2: assert property (
		@(posedge mclk)
		!nrst |-> !divided_clk_out_div2[0] && divided_clk_out_div2_n[0])
		else $error("div2 reset state wrong");

	// Every further copy of a ratio follows copy zero, so the checks
	// above on copy zero stand for all pins of that ratio
	for (gi = 1; gi < N_DIV2; gi++) begin : g_chk2
		AST_COPY2: assert property (
			@(posedge mclk)
			divided_clk_out_div2[gi] == divided_clk_out_div2[0] &&
			divided_clk_out_div2_n[gi] == divided_clk_out_div2_n[0])
			else $error("div2 copies differ");
	end
	for (gi = 1; gi < N_DIV4; gi++) begin : g_chk4
		AST_COPY4: assert property (
			@(posedge mclk)
			divided_clk_out_div4[gi] == divided_clk_out_div4[0] &&
			divided_clk_out_div4_n[gi] == divided_clk_out_div4_n[0])
			else $error("div4 copies differ");
	end

	// Main scenarios: slow edge, each source, open pair toggling
	COV_DIV4_RISE: cover property (@(posedge mclk) disable iff (!nrst)
		$rose(divided_clk_out_div4[0]));
	COV_TTL: cover property (@(posedge mclk) disable iff (!nrst)
		source_sel && rise);
	COV_PECL: cover property (@(posedge mclk) disable iff (!nrst)
		!source_sel && rise);
	COV_OPEN: cover property (@(posedge mclk) disable iff (!nrst)
		diff_pecl_open && !source_sel && diff_pecl_clk_in_p);
endmodule

// [rtl/drcd_pkg.sv]
// Package of constants for the dual ratio clock divider.
// Assumes one synchronous clock mclk; input clocks are sampled levels.
// Operation
// - Reset drives true outputs low, complements high
// - Select low picks differential pair, high TTL
// - Divide-by-two and divide-by-four, half duty cycle
// - Slower rising edges coincide with faster rising edges
// - Open differential pair reads as steady low
package drcd_pkg;
	// Output counts per ratio
	localparam int DIV2_OUTS = 2;
	localparam int DIV4_OUTS = 4;
	// Reset value of the divider phase counter
	localparam logic [1:0] PHASE_RESET = 2'h0;
	// Phase counter bit that forms each ratio
	localparam int DIV2_BIT = 0;
	localparam int DIV4_BIT = 1;
	// Source select codes
	localparam logic SEL_PECL = 1'h0;
	localparam logic SEL_TTL = 1'h1;
endpackage

// [rtl/drcd_out_pair.sv]
// One true/complement output pair driven from a flip-flop each.
// Assumes the level input changes only on mclk edges.
`timescale 1ns/1ps
module drcd_out_pair (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic level,
	output logic q,
	output logic q_n
);
	logic next_q;

	// Complement is the inverse of the true side
	always_comb begin
		next_q = level;
	end

	// Reset forces true low and complement high
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q <= 1'h0;
			q_n <= 1'h1;
		end else begin
			q <= next_q;
			q_n <= ~next_q;
		end
	end
endmodule

// [verif/drcd_src_model.sv]
// Clock source model: differential pair and single-ended clock.
// Assumes half is at least 2, so rises are 4 or more mclk apart.
`timescale 1ns/1ps
module drcd_src_model (
	input wire logic mclk,
	input wire logic [3:0] half,
	input wire logic run_pecl,
	input wire logic run_ttl,
	output logic pecl_p,
	output logic pecl_n,
	output logic ttl
);
	logic [3:0] cnt = 4'h0;
	logic lvl = 1'b0;
	// Level flips every half cycles, just after the edge
	always @(posedge mclk) begin
		cnt <= #1 (cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
		lvl <= #1 (cnt + 4'h1 >= half) ? ~lvl : lvl;
	end
	// A stopped source stands low between bursts
	assign pecl_p = run_pecl & lvl;
	assign pecl_n = ~pecl_p;
	assign ttl = run_ttl & lvl;
endmodule

// [verif/tb.sv]
// Bench for the divider: notes each selected rise, checks outputs.
// Assumes the source model and the default output counts.
`timescale 1ns/1ps
module tb;
	logic mclk = 0, nrst = 1, source_sel = 0, diff_pecl_open = 0;
	logic run_pecl = 0, run_ttl = 0, p, n, ttl, sl, sl_prev = 0;
	logic [3:0] half = 4'h2, u4, u4n, k = 4'h0;
	logic [1:0] u2, u2n;
	logic [11:0] outs, want, prev = 12'h03f;
	logic [11:0] notes[$];
	logic [31:0] seed = 32'hb31074db;
	int miscompares = 0, samples_checked = 0;
	drcd_src_model u_src (.mclk(mclk), .half(half), .run_pecl(run_pecl),
		.run_ttl(run_ttl), .pecl_p(p), .pecl_n(n), .ttl(ttl));
	drcd_top u_dut (.mclk(mclk), .nrst(nrst), .source_sel(source_sel),
		.diff_pecl_clk_in_p(p), .diff_pecl_clk_in_n(n),
		.diff_pecl_open(diff_pecl_open), .ttl_clock_in(ttl),
		.divided_clk_out_div2(u2), .divided_clk_out_div2_n(u2n),
		.divided_clk_out_div4(u4), .divided_clk_out_div4_n(u4n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [11:0] e,
		input logic [11:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task complete_run;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task burst(input logic s, input logic rp, input logic rt, input logic op);
		@(posedge mclk);
		#1;
		seed = lfsr(seed);
		half = 4'h2 + {2'h0, seed[1:0]};
		source_sel = s;
		diff_pecl_open = op;
		run_pecl = rp;
		run_ttl = rt;
		repeat (40) @(posedge mclk);
		#1;
		run_pecl = 0;
		run_ttl = 0;
		repeat (10) @(posedge mclk);
	endtask
	// Clock, 4 ns period
	initial forever #2 mclk = ~mclk;
	// Driver-side notes, taken at the edge where the design samples
	always @(posedge mclk) begin
		sl = source_sel ? ttl : (!diff_pecl_open & p & ~n);
		if (!nrst) begin
			k = 4'h0;
		end else if (sl && !sl_prev) begin
			k = k + 4'h1;
			notes.push_back({{4{k[1] ^ k[0]}}, {2{k[0]}},
				{4{~(k[1] ^ k[0])}}, {2{~k[0]}}});
		end
		// Held low in reset, like the design's previous level
		sl_prev = nrst & sl;
	end
	// Watcher on settled outputs: each change takes the oldest note
	always @(negedge mclk) begin
		outs = {u4, u2, u4n, u2n};
		if (!nrst) begin
			chk("reset outputs", 12'h03f, outs);
			notes.delete();
		end else if (outs !== prev) begin
			if (notes.size() == 0) begin
				chk("idle outputs", prev, outs);
			end else begin
				want = notes.pop_front();
				chk("divided outputs", want, outs);
			end
		end
		prev = outs;
	end
	// Main sequence: both sources, open pair, reset mid-run
	initial begin
		#1 nrst = 0;
		repeat (8) @(posedge mclk);
		#1 nrst = 1;
		repeat (3) begin
			burst(1'b0, 1'b1, 1'b0, 1'b0);
			burst(1'b1, 1'b0, 1'b1, 1'b0);
		end
		burst(1'b0, 1'b1, 1'b0, 1'b1);
		@(posedge mclk);
		#1 run_pecl = 1;
		diff_pecl_open = 0;
		source_sel = 0;
		repeat (15) @(posedge mclk);
		#1 nrst = 0;
		repeat (3) @(posedge mclk);
		#1 nrst = 1;
		burst(1'b0, 1'b1, 1'b0, 1'b0);
		// A stalled divider leaves notes behind
		chk("notes left", 12'h000, 12'(notes.size()));
		complete_run;
	end
	// Hang guard, well past the few hundred cycles needed
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
endmodule
